// file: hdl/adc_regs.svh
// constants for the dram cycle controller
// assumes a 25 mhz system clock (40 ns period)
`ifndef ADC_REGS_SVH
`define ADC_REGS_SVH
`define ADC_CLK_NS          40
`define ADC_INIT_PAUSE_NS   200000
`define ADC_INIT_CYCLES     8
`define ADC_REF_WINDOW_NS   8000000
`define ADC_REF_ROWS        512
`define ADC_RAS_MIN_NS      90
`define ADC_PRECHARGE_NS    60
`define ADC_ACCESS_NS       80
`define ADC_OED_NS          8
`define ADC_CBR_SETUP_NS    10
`define ADC_CBR_HOLD_NS     12
`define ADC_DS_NS           0
`endif

// file: hdl/adc_pkg.sv
// types for the dram cycle controller
// assumes adc_regs.svh is included where counts are needed
package adc_pkg;
	typedef enum logic [1:0] {
		ADC_OP_READ,
		ADC_OP_WRITE,
		ADC_OP_RMW
	} adc_op_type;
	typedef enum logic [3:0] {
		ADC_ST_PAUSE,
		ADC_ST_INIT,
		ADC_ST_IDLE,
		ADC_ST_ROW,
		ADC_ST_COL,
		ADC_ST_OEGAP,
		ADC_ST_WRITE,
		ADC_ST_END,
		ADC_ST_PRE,
		ADC_ST_CBR_CAS,
		ADC_ST_CBR_RAS
	} adc_state_type;
endpackage

// file: hdl/adc_ctrl.sv
// controller driving an asynchronous 256k x 8 dram through its strobes
// assumes pins are synchronous to clk_sys; host request held until ready and its address until the column is taken
`include "adc_regs.svh"
module adc_ctrl #(
	parameter int PAUSE_CYC = (`ADC_INIT_PAUSE_NS + `ADC_CLK_NS - 1) / `ADC_CLK_NS,
	parameter int REF_CYC   = (`ADC_REF_WINDOW_NS / `ADC_REF_ROWS) / `ADC_CLK_NS
) (
	// clock and reset
	input  wire logic                clk_sys,
	input  wire logic                rst,
	// host request
	input  wire logic                req_valid,
	output logic                     req_ready,
	input  wire adc_pkg::adc_op_type req_op,
	input  wire logic [17:0]         req_addr,
	input  wire logic [7:0]          req_wdata,
	input  wire logic                req_page,
	output logic                     rsp_valid,
	output logic [7:0]               rsp_rdata,
	output logic                     init_done,
	// dram pins
	output logic                     ras_n,
	output logic                     cas_n,
	output logic                     we_n,
	output logic                     oe_n,
	output logic [8:0]               dram_addr,
	input  wire logic [7:0]          dq_in,
	output logic [7:0]               dq_out,
	output logic                     dq_oe
);
	import adc_pkg::*;

	function automatic logic [7:0] ns2cyc(input int ns);
		int c;
		c = (ns + `ADC_CLK_NS - 1) / `ADC_CLK_NS;
		if (c < 1)
			c = 1;
		return c[7:0];
	endfunction

	localparam logic [7:0] RAS_CYC = ns2cyc(`ADC_RAS_MIN_NS);
	localparam logic [7:0] PRE_CYC = ns2cyc(`ADC_PRECHARGE_NS);
	localparam logic [7:0] ACC_CYC = ns2cyc(`ADC_ACCESS_NS);
	localparam logic [7:0] OED_CYC = ns2cyc(`ADC_OED_NS);
	localparam logic [7:0] CBS_CYC = ns2cyc(`ADC_CBR_SETUP_NS);
	localparam logic [7:0] CBH_CYC = ns2cyc(`ADC_CBR_HOLD_NS);

	initial begin
		if (PAUSE_CYC < 1 || PAUSE_CYC > 262143 || REF_CYC < 16 || REF_CYC > 65535)
			$error("adc_ctrl: timing parameter out of range");
	end

	typedef struct packed {
		adc_state_type st;
		logic [17:0]   wait_c;
		logic [15:0]   ref_c;
		logic          ref_due;
		logic [3:0]    init_c;
		logic [7:0]    ras_c;
		logic          ras_n;
		logic          cas_n;
		logic          we_n;
		logic          oe_n;
		logic [8:0]    addr;
		logic [8:0]    row;
		logic [7:0]    dq_out;
		logic          dq_oe;
		adc_op_type    op;
		logic [7:0]    wdata;
		logic          rsp_valid;
		logic [7:0]    rdata;
		logic          init_done;
	} adc_state_reg_type;

	adc_state_reg_type s_q;
	adc_state_reg_type s_d;

	logic take;
	logic same_row;

	assign same_row  = req_addr[17:9] == s_q.row;
	assign req_ready = s_q.init_done && !s_q.ref_due &&
		((s_q.st == ADC_ST_IDLE) || (s_q.st == ADC_ST_END && same_row && req_page));
	assign take      = req_valid && req_ready;

	always_comb begin
		s_d = s_q;
		s_d.rsp_valid = 1'b0;
		if (s_q.wait_c != '0)
			s_d.wait_c = s_q.wait_c - 18'd1;
		if (s_q.ras_c != '0)
			s_d.ras_c = s_q.ras_c - 8'd1;
		// -----------------------------------------------
		// refresh interval
		// -----------------------------------------------
		// one row due every window/512
		if (s_q.ref_c == 16'(REF_CYC - 1)) begin
			s_d.ref_c = '0;
			s_d.ref_due = 1'b1;
		end else begin
			s_d.ref_c = s_q.ref_c + 16'd1;
		end
		// -----------------------------------------------
		// cycle sequencer
		// -----------------------------------------------
		case (s_q.st)
			ADC_ST_PAUSE: begin
				s_d.ras_n = 1'b1;
				s_d.cas_n = 1'b1;
				if (s_q.wait_c == '0)
					s_d.st = ADC_ST_PRE;
			end
			ADC_ST_IDLE: begin
				if (s_q.ref_due) begin
					// cas falls first for strobe-order refresh
					// a new due tick in this same cycle must not be lost
					s_d.ref_due = (s_q.ref_c == 16'(REF_CYC - 1));
					s_d.cas_n = 1'b0;
					s_d.ras_c = CBS_CYC;
					s_d.st = ADC_ST_CBR_CAS;
				end else if (take) begin
					s_d.addr = req_addr[17:9];
					s_d.row = req_addr[17:9];
					s_d.op = req_op;
					s_d.wdata = req_wdata;
					s_d.ras_n = 1'b0;
					s_d.ras_c = RAS_CYC;
					s_d.wait_c = 18'd1;
					s_d.st = ADC_ST_ROW;
				end
			end
			ADC_ST_ROW: begin
				if (s_q.wait_c == '0) begin
					// column flows through before cas falls
					s_d.addr = req_addr[8:0] & 9'h1ff;
					s_d.st = ADC_ST_COL;
					s_d.wait_c = 18'(ACC_CYC);
					if (s_q.op == ADC_OP_WRITE) begin
						// early write: we low before cas
						s_d.we_n = 1'b0;
						s_d.oe_n = 1'b1;
						s_d.dq_out = s_q.wdata;
						s_d.dq_oe = 1'b1;
						s_d.st = ADC_ST_WRITE;
						s_d.wait_c = 18'd1;
					end else begin
						s_d.we_n = 1'b1;
						s_d.oe_n = 1'b0;
					end
				end
			end
			ADC_ST_COL: begin
				s_d.cas_n = 1'b0;
				if (s_q.wait_c == '0) begin
					// read data sampled after access time
					s_d.rdata = dq_in;
					if (s_q.op == ADC_OP_RMW) begin
						s_d.oe_n = 1'b1;
						s_d.wait_c = 18'(OED_CYC);
						s_d.st = ADC_ST_OEGAP;
					end else begin
						s_d.rsp_valid = 1'b1;
						s_d.st = ADC_ST_END;
					end
				end
			end
			ADC_ST_OEGAP: begin
				if (s_q.wait_c == '0) begin
					if (!s_q.dq_oe) begin
						s_d.dq_out = s_q.wdata;
						s_d.dq_oe = 1'b1;
					end else begin
						// data settled a cycle before we falls
						s_d.we_n = 1'b0;
						s_d.wait_c = 18'd1;
						s_d.st = ADC_ST_WRITE;
					end
				end
			end
			ADC_ST_WRITE: begin
				s_d.cas_n = 1'b0;
				if (s_q.wait_c == '0) begin
					s_d.rsp_valid = 1'b1;
					s_d.st = ADC_ST_END;
				end
			end
			ADC_ST_END: begin
				s_d.cas_n = 1'b1;
				s_d.we_n = 1'b1;
				s_d.dq_oe = 1'b0;
				if (take) begin
					s_d.op = req_op;
					s_d.wdata = req_wdata;
					s_d.wait_c = '0;
					s_d.st = ADC_ST_ROW;
				end else if (s_q.ras_c == '0 && s_q.cas_n) begin
					s_d.ras_n = 1'b1;
					s_d.oe_n = 1'b1;
					s_d.wait_c = 18'(PRE_CYC);
					s_d.st = ADC_ST_PRE;
				end
			end
			ADC_ST_PRE: begin
				s_d.ras_n = 1'b1;
				s_d.cas_n = 1'b1;
				if (s_q.wait_c == '0) begin
					if (!s_q.init_done) begin
						s_d.st = ADC_ST_INIT;
					end else begin
						s_d.st = ADC_ST_IDLE;
					end
				end
			end
			ADC_ST_INIT: begin
				if (s_q.init_c == 4'(`ADC_INIT_CYCLES)) begin
					s_d.init_done = 1'b1;
					s_d.st = ADC_ST_IDLE;
				end else begin
					s_d.init_c = s_q.init_c + 4'd1;
					s_d.cas_n = 1'b0;
					s_d.ras_c = CBS_CYC;
					s_d.st = ADC_ST_CBR_CAS;
				end
			end
			ADC_ST_CBR_CAS: begin
				if (s_q.ras_c == '0) begin
					// address left idle, device counter used
					s_d.ras_n = 1'b0;
					s_d.we_n = 1'b1;
					s_d.ras_c = RAS_CYC;
					s_d.wait_c = 18'(CBH_CYC);
					s_d.st = ADC_ST_CBR_RAS;
				end
			end
			ADC_ST_CBR_RAS: begin
				if (s_q.wait_c == '0)
					s_d.cas_n = 1'b1;
				if (s_q.ras_c == '0 && s_d.cas_n) begin
					// previous read data kept in rdata
					s_d.ras_n = 1'b1;
					s_d.wait_c = 18'(PRE_CYC);
					s_d.st = ADC_ST_PRE;
				end
			end
			default: begin
				s_d.st = ADC_ST_PRE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_q <= '0;
			s_q.st <= ADC_ST_PAUSE;
			s_q.wait_c <= 18'(PAUSE_CYC);
			s_q.ras_n <= 1'b1;
			s_q.cas_n <= 1'b1;
			s_q.we_n <= 1'b1;
			s_q.oe_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign ras_n     = s_q.ras_n;
	assign cas_n     = s_q.cas_n;
	assign we_n      = s_q.we_n;
	assign oe_n      = s_q.oe_n;
	assign dram_addr = s_q.addr;
	assign dq_out    = s_q.dq_out;
	assign dq_oe     = s_q.dq_oe;
	assign rsp_valid = s_q.rsp_valid;
	assign rsp_rdata = s_q.rdata;
	assign init_done = s_q.init_done;
endmodule

// file: tb/adc_ctrl_chk.sv
// pin-level assertions for the dram controller
// assumes bind onto adc_ctrl, single clock domain
module adc_ctrl_chk (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic dq_oe,
	input wire logic init_done
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] ras_cnt_q;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence s_ras_open; $fell(ras_n); endsequence
	sequence s_cbr_open; $fell(ras_n) ##0 !cas_n; endsequence
	// saturates so a long run cannot wrap
	always_ff @(posedge clk_sys) begin
		if (rst)
			ras_cnt_q <= 4'h0;
		else if ($fell(ras_n) && ras_cnt_q != 4'hf)
			ras_cnt_q <= ras_cnt_q + 4'h1;
	end
	AST_RST_IDLE: assert property ($fell(rst) |-> ras_n && cas_n && !dq_oe) else $error("strobes active at reset exit");
	AST_RAS_MIN: assert property (s_ras_open |-> !ras_n[*3]) else $error("row strobe low too short");
	AST_CBR_QUIET: assert property (s_cbr_open |-> we_n && !dq_oe) else $error("refresh with data access");
	AST_WR_ROW: assert property (!cas_n && !we_n |-> !ras_n) else $error("write without row strobe");
	AST_WR_DATA: assert property ($fell(cas_n) && !we_n |-> dq_oe) else $error("no data at early write");
	AST_LATE_OE: assert property ($fell(we_n) && !cas_n |-> oe_n && $past(oe_n)) else $error("oe not high before late we");
	AST_NO_CLASH: assert property (dq_oe |-> oe_n || cas_n || !we_n || ras_n) else $error("bus driven by both");
	AST_INIT_CNT: assert property ($rose(init_done) |-> ras_cnt_q >= 4'h8) else $error("too few init cycles");
endmodule
bind adc_ctrl adc_ctrl_chk adc_ctrl_chk_i (.clk_sys(clk_sys), .rst(rst), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
	.oe_n(oe_n), .dq_oe(dq_oe), .init_done(init_done));

// file: tb/adc_dram_model.sv
// behavioural 256k x 8 dram on the controller pins
// assumes strobes from the controller; no clock of its own
module adc_dram_model (
	input wire logic       ras_n,
	input wire logic       cas_n,
	input wire logic       we_n,
	input wire logic       oe_n,
	input wire logic [8:0] addr,
	input wire logic [7:0] din,
	output logic [7:0]     dout
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [0:262143];
	logic [8:0] row;
	logic [8:0] col;
	logic [8:0] rcnt = 9'h000;
	logic       cbr = 1'b0;
	logic [7:0] last = 8'h00;
	always @(negedge ras_n) begin
		cbr = !cas_n;
		if (cbr)
			rcnt = rcnt + 9'h001;
		else
			row = addr;
	end
	always @(negedge cas_n) if (!ras_n && !cbr) begin
		col = addr;
		if (!we_n)
			mem[{row, col}] = din;
	end
	always @(negedge we_n) if (!ras_n && !cas_n && !cbr)
		mem[{row, col}] = din;
	always @* begin
		if (!ras_n && !cas_n && !oe_n && we_n && !cbr) begin
			dout = mem[{row, col}];
			last = dout;
		end else
			dout = ~last;
	end
endmodule

// file: tb/tb_adc_ctrl.sv
// self-checking bench for the dram controller
// assumes adc_dram_model stands on the dram pins
module tb_adc_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	import adc_pkg::*;
	logic       clk_sys = 1'b0;
	logic       rst = 1'b1;
	logic       req_valid = 1'b0;
	logic       req_page = 1'b0;
	adc_op_type req_op = ADC_OP_READ;
	logic [17:0] req_addr = 18'h0_0000;
	logic [7:0] req_wdata = 8'h00;
	logic       req_ready, rsp_valid, init_done, ras_n, cas_n, we_n, oe_n, dq_oe;
	logic [7:0] rsp_rdata, dq_in, dq_out;
	logic [8:0] dram_addr;
	int         n_errors = 0, tests_run = 0, cyc = 0, n_ras = 0, n_cbr = 0, c;
	adc_ctrl #(.PAUSE_CYC(10), .REF_CYC(40)) adc_ctrl_i (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid),
		.req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata), .req_page(req_page),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .init_done(init_done), .ras_n(ras_n), .cas_n(cas_n),
		.we_n(we_n), .oe_n(oe_n), .dram_addr(dram_addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
	adc_dram_model adc_dram_model_i (.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n), .addr(dram_addr),
		.din(dq_out), .dout(dq_in));
	initial begin
		forever #20 clk_sys = ~clk_sys;
	end
	always @(negedge ras_n) begin
		n_ras++;
		if (!cas_n)
			n_cbr++;
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			close_out;
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task close_out;
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// address held through the access for the flow-through latch
	task op(input adc_op_type o, input logic [17:0] a, input logic [7:0] d, input logic pg);
		int k;
		k = 0;
		req_op = o;
		req_addr = a;
		req_wdata = d;
		req_page = pg;
		req_valid = 1'b1;
		while (req_ready !== 1'b1 && k < 500) begin
			@(negedge clk_sys);
			k++;
		end
		@(negedge clk_sys);
		req_valid = 1'b0;
		req_page = 1'b0;
		k = 0;
		while (rsp_valid !== 1'b1 && k < 500) begin
			@(negedge clk_sys);
			k++;
		end
		chk({31'h0, rsp_valid}, 32'h0000_0001);
	endtask
	task t_wr_rd;
		op(ADC_OP_WRITE, 18'h0_0000, 8'h5a, 1'b0);
		op(ADC_OP_WRITE, 18'h3_ffff, 8'ha5, 1'b0);
		op(ADC_OP_WRITE, 18'h1_5a3c, 8'h3c, 1'b0);
		op(ADC_OP_READ, 18'h0_0000, 8'h00, 1'b0);
		chk({24'h0, rsp_rdata}, 32'h0000_005a);
		op(ADC_OP_READ, 18'h3_ffff, 8'h00, 1'b0);
		chk({24'h0, rsp_rdata}, 32'h0000_00a5);
		op(ADC_OP_READ, 18'h1_5a3c, 8'h00, 1'b0);
		chk({24'h0, rsp_rdata}, 32'h0000_003c);
	endtask
	task t_rmw;
		op(ADC_OP_RMW, 18'h1_5a3c, 8'hc3, 1'b0);
		chk({24'h0, rsp_rdata}, 32'h0000_003c);
		op(ADC_OP_READ, 18'h1_5a3c, 8'h00, 1'b0);
		chk({24'h0, rsp_rdata}, 32'h0000_00c3);
	endtask
	task t_page;
		op(ADC_OP_WRITE, 18'h0_a001, 8'h11, 1'b0);
		op(ADC_OP_WRITE, 18'h0_a1ff, 8'h22, 1'b1);
		op(ADC_OP_READ, 18'h0_a001, 8'h00, 1'b0);
		chk({24'h0, rsp_rdata}, 32'h0000_0011);
		op(ADC_OP_READ, 18'h0_a1ff, 8'h00, 1'b1);
		chk({24'h0, rsp_rdata}, 32'h0000_0022);
	endtask
	task t_refresh;
		c = n_cbr;
		repeat (100) @(negedge clk_sys);
		chk({31'h0, n_cbr - c >= 2}, 32'h0000_0001);
		op(ADC_OP_READ, 18'h3_ffff, 8'h00, 1'b0);
		chk({24'h0, rsp_rdata}, 32'h0000_00a5);
	endtask
	initial begin
		repeat (10) @(negedge clk_sys);
		chk({28'h0, ras_n, cas_n, we_n, dq_oe}, 32'h0000_000e);
		n_ras = 0;
		rst = 1'b0;
		while (init_done !== 1'b1 && cyc < 2000) @(negedge clk_sys);
		chk({31'h0, n_ras >= 8}, 32'h0000_0001);
		t_wr_rd;
		t_rmw;
		t_page;
		t_refresh;
		close_out;
	end
endmodule
